// [hdl/rpc_port_config_regs.sv]
// port one configuration and interrupt-enable registers with pass-through routing
`default_nettype none
module rpc_port_config_regs
  import rpc_pkg::*;
(
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic srst_in,
  input  wire logic active_low_reset_pin_in,
  // serial register port
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  // general pins
  input  wire logic general_pin_a_in,
  input  wire logic general_pin_b_in,
  input  wire logic pin_b_trigger_kind_in,
  // repeater status from port one
  input  wire logic link_connected_in,
  input  wire logic disconnect_event_in,
  input  wire logic remote_wake_event_in,
  input  wire logic suspend_irq_mode_in,
  input  wire logic irq_ack_in,
  output logic      port_enabled_out,
  // embedded side data pins
  input  wire logic edp_in,
  output logic      edp_out,
  output logic      edp_oe_out,
  input  wire logic edm_in,
  output logic      edm_out,
  output logic      edm_oe_out,
  // legacy side data pins
  input  wire logic dp_in,
  output logic      dp_out,
  output logic      dp_oe_out,
  input  wire logic dm_in,
  output logic      dm_out,
  output logic      dm_oe_out,
  // interrupt output pin
  output logic      interrupt_output_pin_out,
  output logic      interrupt_output_pin_oe_out
);
  logic [RPC_SYNC_W-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
  logic [7:0] serial_reg;
  logic [7:0] control_reg;
  logic [7:0] irq_en_reg;
  logic [3:0] pend_reg;
  logic       soft_rst_reg;
  logic       port_disabled_reg;
  logic       pin_b_prev_reg;
  logic       scl_f_reg, sda_f_reg;
  logic [7:0] rd_addr, wr_addr, wr_data, rd_data;
  logic       wr_strobe;

  // pin synchronisers: a change counts once stages two and three agree
  wire [RPC_SYNC_W-1:0] raw   = {dm_in, dp_in, edm_in, edp_in, active_low_reset_pin_in,
                                 general_pin_b_in, general_pin_a_in};
  wire [RPC_SYNC_W-1:0] agree = ~(s2_reg ^ s3_reg);
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      s1_reg   <= RPC_SYNC_RST;
      s2_reg   <= RPC_SYNC_RST;
      s3_reg   <= RPC_SYNC_RST;
      filt_reg <= RPC_SYNC_RST;
    end else begin
      s1_reg   <= raw;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= (s2_reg & agree) | (filt_reg & ~agree);
    end
  end
  wire pin_a   = filt_reg[0];
  wire pin_b   = filt_reg[1];
  wire pin_rst = ~filt_reg[2];
  wire edp_s   = filt_reg[3];
  wire edm_s   = filt_reg[4];
  wire dp_s    = filt_reg[5];
  wire dm_s    = filt_reg[6];

  wire hard_rst = srst_in | pin_rst;
  wire dev_rst  = hard_rst | soft_rst_reg;

  // serial bus lines pass the same three-stage filter
  logic [2:0] scl_sh_reg, sda_sh_reg;
  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      scl_sh_reg <= 3'h7;
      sda_sh_reg <= 3'h7;
      scl_f_reg  <= 1'b1;
      sda_f_reg  <= 1'b1;
    end else begin
      scl_sh_reg <= {scl_sh_reg[1:0], scl_in};
      sda_sh_reg <= {sda_sh_reg[1:0], sda_in};
      scl_f_reg  <= (scl_sh_reg[1] == scl_sh_reg[2]) ? scl_sh_reg[2] : scl_f_reg;
      sda_f_reg  <= (sda_sh_reg[1] == sda_sh_reg[2]) ? sda_sh_reg[2] : sda_f_reg;
    end
  end

  // serial target; not cleared by soft reset so the ack still completes
  rpc_serial_target u_target (
    .ref_clk_in    (ref_clk_in),
    .srst_in       (hard_rst),
    .scl_in        (scl_f_reg),
    .sda_in        (sda_f_reg),
    .sda_oe_out    (sda_oe_out),
    .rd_data_in    (rd_data),
    .rd_addr_out   (rd_addr),
    .wr_addr_out   (wr_addr),
    .wr_data_out   (wr_data),
    .wr_strobe_out (wr_strobe)
  );

  // register decode and read mux; unmapped offsets read zero
  wire wr_serial  = wr_strobe & (wr_addr == RPC_OFS_SERIAL);
  wire wr_control = wr_strobe & (wr_addr == RPC_OFS_CONTROL);
  wire wr_irq_en  = wr_strobe & (wr_addr == RPC_OFS_IRQ_EN);
  assign rd_data = (rd_addr == RPC_OFS_SERIAL)   ? serial_reg :
                   (rd_addr == RPC_OFS_REVISION) ? RPC_REVISION_CODE :
                   (rd_addr == RPC_OFS_CONTROL)  ? control_reg :
                   (rd_addr == RPC_OFS_IRQ_EN)   ? irq_en_reg : 8'h00;

  // register writes; reserved read-only bits stay zero through the masks
  always_ff @(posedge ref_clk_in) begin
    if (dev_rst) begin
      serial_reg  <= RPC_SERIAL_RST;
      control_reg <= RPC_CONTROL_RST;
      irq_en_reg  <= RPC_IRQ_EN_RST;
    end else begin
      if (wr_serial) serial_reg <= wr_data & RPC_SERIAL_MASK;
      if (wr_control) control_reg <= wr_data & RPC_CONTROL_MASK;
      if (wr_irq_en) irq_en_reg <= wr_data & RPC_IRQ_EN_MASK;
    end
  end

  // self-clearing reset pulse, one cycle long
  always_ff @(posedge ref_clk_in) begin
    if (hard_rst) soft_rst_reg <= 1'b0;
    else soft_rst_reg <= wr_control & wr_data[RPC_SOFT_RESET_BIT];
  end

  // shutdown waits for link loss; holds while the bit stays set
  wire shutdown_bit = control_reg[RPC_PORT_SHUTDOWN_BIT];
  wire disable_next = shutdown_bit & (port_disabled_reg | ~link_connected_in | disconnect_event_in);
  always_ff @(posedge ref_clk_in) begin
    if (dev_rst) begin
      port_disabled_reg <= 1'b0;
      port_enabled_out  <= 1'b0;
    end else begin
      port_disabled_reg <= disable_next;
      port_enabled_out  <= ~disable_next;
    end
  end

  wire use_reg_src = serial_reg[RPC_PASSTHROUGH_GATE_BIT] & serial_reg[RPC_PASSTHROUGH_SELECT_BIT];
  wire pt_enable = use_reg_src ? serial_reg[RPC_PASSTHROUGH_ENABLE_BIT] : pin_a;
  wire pt_active = pt_enable & ~port_disabled_reg;

  wire flip       = serial_reg[RPC_PASSTHROUGH_FLIP_BIT];
  wire leg_src    = flip ? dm_s : dp_s;
  wire emb_out_m  = serial_reg[RPC_PASSTHROUGH_SWAP_BIT] ^ flip;
  wire emb_src    = emb_out_m ? edp_s : edm_s;

  // pass-through drivers; a pin only drives while it is the chosen output
  always_ff @(posedge ref_clk_in) begin
    if (dev_rst) begin
      {edp_out, edm_out, dp_out, dm_out}             <= 4'h0;
      {edp_oe_out, edm_oe_out, dp_oe_out, dm_oe_out} <= 4'h0;
    end else begin
      edp_out    <= leg_src;
      edm_out    <= leg_src;
      dp_out     <= emb_src;
      dm_out     <= emb_src;
      edp_oe_out <= pt_active & ~emb_out_m;
      edm_oe_out <= pt_active & emb_out_m;
      dp_oe_out  <= pt_active & flip;
      dm_oe_out  <= pt_active & ~flip;
    end
  end

  // interrupt sources: pending bits hi-edge, lo-edge, wake, disconnect
  wire trig_level = pin_b_trigger_kind_in;
  wire b_hi_en    = irq_en_reg[RPC_PIN_B_HIGH_BIT];
  wire b_lo_en    = irq_en_reg[RPC_PIN_B_LOW_BIT];
  wire wake_en    = irq_en_reg[RPC_WAKE_BIT];
  wire disc_en    = irq_en_reg[RPC_DISCONNECT_BIT];
  wire b_rise     = pin_b & ~pin_b_prev_reg;
  wire b_fall     = ~pin_b & pin_b_prev_reg;
  wire [3:0] set_ev = {suspend_irq_mode_in & disc_en & disconnect_event_in,
                       suspend_irq_mode_in & wake_en & remote_wake_event_in,
                       ~trig_level & b_lo_en & b_fall,
                       ~trig_level & b_hi_en & b_rise};
  wire level_hit  = trig_level & ((b_hi_en & pin_b) | (b_lo_en & ~pin_b));
  wire [3:0] en_vec = {disc_en, wake_en, b_lo_en, b_hi_en};
  // only enabled sources reach the pin
  wire irq_active = (|(pend_reg & en_vec)) | level_hit;

  // sticky pending; a new event in the ack cycle wins over the clear
  always_ff @(posedge ref_clk_in) begin
    if (dev_rst) begin
      pend_reg       <= 4'h0;
      pin_b_prev_reg <= 1'b0;
    end else begin
      pend_reg       <= set_ev | (pend_reg & {4{~irq_ack_in}});
      pin_b_prev_reg <= pin_b;
    end
  end

  wire push_pull = control_reg[RPC_IRQ_DRIVE_KIND_BIT];
  wire act_low   = control_reg[RPC_IRQ_LEVEL_BIT];
  always_ff @(posedge ref_clk_in) begin
    if (dev_rst) begin
      interrupt_output_pin_out    <= 1'b0;
      interrupt_output_pin_oe_out <= 1'b0;
      sda_out                     <= 1'b0;
    end else begin
      interrupt_output_pin_out    <= push_pull & (irq_active ^ act_low);
      interrupt_output_pin_oe_out <= push_pull | irq_active;
      sda_out                     <= 1'b0;
    end
  end
endmodule // rpc_port_config_regs
`default_nettype wire

// [hdl/rpc_pkg.sv]
// constants for the repeater port configuration register bank
// Functional notes
// - serial bit 4 pairs plus/minus straight when clear, crossed when set
// - serial bit 2 picks pass-through direction; set reverses both directions
// - serial bit 1, reset one, picks register bit or general pin a
// - serial bit 0 enables pass-through when the pin is not the source
// - serial bit 3 clear ignores bit 1; general pin a then enables
// - writing one to control bit 7 resets like the reset pin low; the serial target is not reset by it
// - control bit 6 disables port one; while connected, waits for disconnect
// - control bit 4 selects interrupt pin open drain or push-pull
// - control bit 3 sets push-pull active level; open drain always active low
// - enable bit 7: pin b rising edge, or high level, interrupt
// - enable bit 6: pin b falling edge, or low level, interrupt
// - enable bit 3 gates remote-wake interrupt in suspend interrupt mode
// - enable bit 2 gates disconnect interrupt in suspend interrupt mode
// - interrupt pin shows assertion per its configured output stage
`default_nettype none
package rpc_pkg;
  // register offsets
  localparam logic [7:0] RPC_OFS_SERIAL   = 8'h50;
  localparam logic [7:0] RPC_OFS_REVISION = 8'hB0;
  localparam logic [7:0] RPC_OFS_CONTROL  = 8'hB2;
  localparam logic [7:0] RPC_OFS_IRQ_EN   = 8'hB3;
  // reset values and writable bit masks
  localparam logic [7:0] RPC_SERIAL_RST   = 8'h02;
  localparam logic [7:0] RPC_CONTROL_RST  = 8'h00;
  localparam logic [7:0] RPC_IRQ_EN_RST   = 8'h00;
  localparam logic [7:0] RPC_SERIAL_MASK  = 8'hDF;
  localparam logic [7:0] RPC_CONTROL_MASK = 8'h58;
  localparam logic [7:0] RPC_IRQ_EN_MASK  = 8'hCC;
  // arbitrary neutral revision code
  localparam logic [7:0] RPC_REVISION_CODE = 8'h5A;
  // arbitrary default target address
  localparam logic [6:0] RPC_TARGET_ADDR  = 7'h2C;
  // serial-mode field positions
  localparam int RPC_PASSTHROUGH_ENABLE_BIT = 0;
  localparam int RPC_PASSTHROUGH_SELECT_BIT = 1;
  localparam int RPC_PASSTHROUGH_FLIP_BIT   = 2;
  localparam int RPC_PASSTHROUGH_GATE_BIT   = 3;
  localparam int RPC_PASSTHROUGH_SWAP_BIT   = 4;
  // global control field positions
  localparam int RPC_SOFT_RESET_BIT     = 7;
  localparam int RPC_PORT_SHUTDOWN_BIT  = 6;
  localparam int RPC_IRQ_DRIVE_KIND_BIT = 4;
  localparam int RPC_IRQ_LEVEL_BIT      = 3;
  // interrupt enable field positions
  localparam int RPC_PIN_B_HIGH_BIT     = 7;
  localparam int RPC_PIN_B_LOW_BIT      = 6;
  localparam int RPC_WAKE_BIT           = 3;
  localparam int RPC_DISCONNECT_BIT     = 2;
  // pin synchroniser lanes: a, b, reset, edp, edm, dp, dm
  localparam int          RPC_SYNC_W   = 7;
  localparam logic [6:0]  RPC_SYNC_RST = 7'h04;
  // serial target bit counter full value
  localparam logic [3:0]  RPC_BITS_PER_BYTE = 4'h8;
  // serial target states, gray along the usual path
  typedef enum logic [2:0] {
    RPC_ST_IDLE  = 3'h0,
    RPC_ST_ADDR  = 3'h1,
    RPC_ST_AACK  = 3'h3,
    RPC_ST_WBYTE = 3'h2,
    RPC_ST_WACK  = 3'h6,
    RPC_ST_RBYTE = 3'h7,
    RPC_ST_RACK  = 3'h5
  } rpc_state_e;
endpackage : rpc_pkg
`default_nettype wire

// [hdl/rpc_serial_target.sv]
// two-wire serial target giving byte access to the register bank
`default_nettype none
module rpc_serial_target
  import rpc_pkg::*;
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       srst_in,
  // filtered bus levels
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_oe_out,
  // register access
  input  wire logic [7:0] rd_data_in,
  output logic [7:0]      rd_addr_out,
  output logic [7:0]      wr_addr_out,
  output logic [7:0]      wr_data_out,
  output logic            wr_strobe_out
);
  rpc_state_e state_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic [3:0] cnt_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;
  logic       read_reg;
  logic       first_reg;
  logic       nack_reg;

  // bus events from filtered levels
  wire scl_rise = scl_in & ~scl_prev_reg;
  wire scl_fall = ~scl_in & scl_prev_reg;
  wire start_ev = scl_in & scl_prev_reg & sda_prev_reg & ~sda_in;
  wire stop_ev  = scl_in & scl_prev_reg & ~sda_prev_reg & sda_in;
  wire full     = (cnt_reg == RPC_BITS_PER_BYTE);
  wire addr_hit = (shift_reg[7:1] == RPC_TARGET_ADDR);

  assign rd_addr_out = ptr_reg;

  // byte engine: sample on rising clock, change data on falling clock
  always_ff @(posedge ref_clk_in) begin
    scl_prev_reg  <= scl_in;
    sda_prev_reg  <= sda_in;
    wr_strobe_out <= 1'b0;
    if (srst_in) begin
      state_reg    <= RPC_ST_IDLE;
      shift_reg    <= 8'h00;
      ptr_reg      <= 8'h00;
      cnt_reg      <= 4'h0;
      read_reg     <= 1'b0;
      first_reg    <= 1'b0;
      nack_reg     <= 1'b0;
      sda_oe_out   <= 1'b0;
      wr_addr_out  <= 8'h00;
      wr_data_out  <= 8'h00;
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else if (start_ev) begin
      // a repeated start is accepted anywhere
      state_reg  <= RPC_ST_ADDR;
      cnt_reg    <= 4'h0;
      sda_oe_out <= 1'b0;
    end else if (stop_ev) begin
      state_reg  <= RPC_ST_IDLE;
      sda_oe_out <= 1'b0;
    end else if (scl_rise) begin
      if (state_reg == RPC_ST_ADDR || state_reg == RPC_ST_WBYTE) begin
        shift_reg <= {shift_reg[6:0], sda_in};
        cnt_reg   <= cnt_reg + 4'h1;
      end else if (state_reg == RPC_ST_RBYTE) begin
        shift_reg <= {shift_reg[6:0], 1'b0};
        cnt_reg   <= cnt_reg + 4'h1;
      end else if (state_reg == RPC_ST_RACK) begin
        nack_reg <= sda_in;
        ptr_reg  <= ptr_reg + 8'h01;
      end
    end else if (scl_fall) begin
      case (state_reg)
        RPC_ST_ADDR: begin
          if (full && addr_hit) begin
            state_reg  <= RPC_ST_AACK;
            read_reg   <= shift_reg[0];
            sda_oe_out <= 1'b1;
          end else if (full) begin
            state_reg <= RPC_ST_IDLE;
          end
        end
        RPC_ST_AACK: begin
          cnt_reg <= 4'h0;
          if (read_reg) begin
            state_reg  <= RPC_ST_RBYTE;
            shift_reg  <= rd_data_in;
            sda_oe_out <= ~rd_data_in[7];
          end else begin
            state_reg  <= RPC_ST_WBYTE;
            first_reg  <= 1'b1;
            sda_oe_out <= 1'b0;
          end
        end
        RPC_ST_WBYTE: begin
          if (full) begin
            state_reg  <= RPC_ST_WACK;
            sda_oe_out <= 1'b1;
            first_reg  <= 1'b0;
            if (first_reg) begin
              ptr_reg <= shift_reg;
            end else begin
              wr_addr_out   <= ptr_reg;
              wr_data_out   <= shift_reg;
              wr_strobe_out <= 1'b1;
              ptr_reg       <= ptr_reg + 8'h01;
            end
          end
        end
        RPC_ST_WACK: begin
          state_reg  <= RPC_ST_WBYTE;
          cnt_reg    <= 4'h0;
          sda_oe_out <= 1'b0;
        end
        RPC_ST_RBYTE: begin
          if (full) begin
            state_reg  <= RPC_ST_RACK;
            sda_oe_out <= 1'b0;
          end else begin
            sda_oe_out <= ~shift_reg[7];
          end
        end
        RPC_ST_RACK: begin
          // controller nack ends the read until the next start
          cnt_reg <= 4'h0;
          if (nack_reg) begin
            state_reg <= RPC_ST_IDLE;
          end else begin
            state_reg  <= RPC_ST_RBYTE;
            shift_reg  <= rd_data_in;
            sda_oe_out <= ~rd_data_in[7];
          end
        end
        default: begin
          state_reg  <= RPC_ST_IDLE;
          sda_oe_out <= 1'b0;
        end
      endcase
    end
  end
endmodule // rpc_serial_target
`default_nettype wire

// [testbench/rpc_port_config_regs_assertions.sv]
// pin-level assertions on the port configuration register bank
`default_nettype none
module rpc_port_config_regs_assertions (
  // clock and resets
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic active_low_reset_pin_in,
  // port status
  input wire logic link_connected_in,
  input wire logic disconnect_event_in,
  input wire logic port_enabled_out,
  // data pins
  input wire logic edp_in,
  input wire logic edm_in,
  input wire logic dp_in,
  input wire logic dm_in,
  input wire logic edp_out,
  input wire logic dp_out,
  input wire logic edp_oe_out,
  input wire logic edm_oe_out,
  input wire logic dp_oe_out,
  input wire logic dm_oe_out,
  // interrupt pin
  input wire logic interrupt_output_pin_out,
  input wire logic interrupt_output_pin_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // one clock domain, reset disables every check
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  a_od_idle_low: assert property (!interrupt_output_pin_oe_out |-> !interrupt_output_pin_out)
    else $error("undriven interrupt pin carries a high value");
  a_reset_quiet: assert property ($fell(srst_in) |-> !interrupt_output_pin_oe_out [*8])
    else $error("interrupt pin asserted with no source enabled");
  a_pin_reset: assert property (!active_low_reset_pin_in [*6]
    |-> !port_enabled_out && !interrupt_output_pin_oe_out)
    else $error("reset pin held low did not reset outputs");
  a_wait_disc: assert property (port_enabled_out && link_connected_in && !disconnect_event_in
    |=> port_enabled_out)
    else $error("connected port dropped without a disconnect");
  // long enough off that the routing flops have caught up
  a_off_blocks: assert property (!port_enabled_out [*3]
    |-> !(dp_oe_out || dm_oe_out || edp_oe_out || edm_oe_out))
    else $error("pass-through driving while port disabled");
  a_one_out: assert property (!(dp_oe_out && dm_oe_out) && !(edp_oe_out && edm_oe_out))
    else $error("both pins of one side driven");
  a_side_pair: assert property ((edp_oe_out || edm_oe_out) == (dp_oe_out || dm_oe_out))
    else $error("pass-through drives only one side");
  a_leg_data: assert property ((dp_oe_out && $stable(edp_in) && $stable(edm_in) && $stable(edp_oe_out)) [*6]
    |-> dp_out == (edp_oe_out ? edm_in : edp_in))
    else $error("legacy output does not follow embedded input");
  a_emb_data: assert property ((edp_oe_out && $stable(dp_in) && $stable(dm_in) && $stable(dp_oe_out)) [*6]
    |-> edp_out == (dp_oe_out ? dm_in : dp_in))
    else $error("embedded output does not follow legacy input");
endmodule // rpc_port_config_regs_assertions

bind rpc_port_config_regs rpc_port_config_regs_assertions i_chk (.ref_clk_in, .srst_in, .active_low_reset_pin_in,
  .link_connected_in, .disconnect_event_in, .port_enabled_out, .edp_in, .edm_in, .dp_in, .dm_in, .edp_out, .dp_out,
  .edp_oe_out, .edm_oe_out, .dp_oe_out, .dm_oe_out, .interrupt_output_pin_out, .interrupt_output_pin_oe_out);
`default_nettype wire

// [testbench/rpc_host_model.sv]
// serial bus controller standing in for the host processor
`default_nettype none
module rpc_host_model
  import rpc_pkg::*;
(
  // clock and bus
  input  wire logic ref_clk_in,
  input  wire logic sda_in,
  output var logic  scl_out = 1'b1,
  output var logic  sda_low_out = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // quarter bit time, well clear of the target's input filter lag
  localparam int QTR = 6;
  int nacks = 0;
  task automatic gap();
    repeat (QTR) @(negedge ref_clk_in);
  endtask
  // data moves only while scl is low; level sampled mid-high
  task automatic bit_io(input logic b, output logic seen);
    sda_low_out = !b;
    gap();
    scl_out = 1'b1;
    gap();
    seen = sda_in;
    gap();
    scl_out = 1'b0;
    gap();
  endtask
  // start also serves as repeated start
  task automatic start();
    sda_low_out = 1'b0;
    gap();
    scl_out = 1'b1;
    gap();
    sda_low_out = 1'b1;
    gap();
    scl_out = 1'b0;
    gap();
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    gap();
    scl_out = 1'b1;
    gap();
    sda_low_out = 1'b0;
    gap();
  endtask
  // one byte msb first, then the acknowledge slot with sda released
  task automatic xfer(input logic [7:0] d, input logic chk, output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(1'b1, a);
    if (chk && (a !== 1'b0)) begin
      nacks++;
    end
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] d);
    logic [7:0] q;
    start();
    xfer({RPC_TARGET_ADDR, 1'b0}, 1'b1, q);
    xfer(ofs, 1'b1, q);
    xfer(d, 1'b1, q);
    stop();
  endtask
  // single byte read, closed with a nack
  task automatic rd(input logic [7:0] ofs, output logic [7:0] d);
    logic [7:0] q;
    start();
    xfer({RPC_TARGET_ADDR, 1'b0}, 1'b1, q);
    xfer(ofs, 1'b1, q);
    start();
    xfer({RPC_TARGET_ADDR, 1'b1}, 1'b1, q);
    xfer(8'hFF, 1'b0, d);
    stop();
  endtask
endmodule // rpc_host_model
`default_nettype wire

// [testbench/rpc_port_config_regs_tb_top.sv]
// self-checking bench for the port configuration register bank
`default_nettype none
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module rpc_port_config_regs_tb_top
  import rpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in = 1'b0, srst_in = 1'b1, active_low_reset_pin_in = 1'b1;
  logic general_pin_a_in = 1'b0, general_pin_b_in = 1'b0, pin_b_trigger_kind_in = 1'b0;
  logic link_connected_in = 1'b0, disconnect_event_in = 1'b0, remote_wake_event_in = 1'b0;
  logic suspend_irq_mode_in = 1'b0, irq_ack_in = 1'b0, pp = 1'b0, lo = 1'b0;
  logic edp_drv = 1'b0, edm_drv = 1'b0, dp_drv = 1'b0, dm_drv = 1'b0;
  logic scl_in, sda_low, sda_out, sda_oe_out, port_enabled_out;
  logic edp_out, edp_oe_out, edm_out, edm_oe_out, dp_out, dp_oe_out, dm_out, dm_oe_out;
  logic interrupt_output_pin_out, interrupt_output_pin_oe_out;
  int   fail_count = 0, checked = 0;
  // wire levels resolved from every driver; sda has a pull-up
  wire sda_in = !(sda_low || (sda_oe_out && !sda_out));
  wire edp_in = edp_oe_out ? edp_out : edp_drv;
  wire edm_in = edm_oe_out ? edm_out : edm_drv;
  wire dp_in  = dp_oe_out ? dp_out : dp_drv;
  wire dm_in  = dm_oe_out ? dm_out : dm_drv;
  rpc_port_config_regs i_dut (.ref_clk_in, .srst_in, .active_low_reset_pin_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
    .general_pin_a_in, .general_pin_b_in, .pin_b_trigger_kind_in, .link_connected_in, .disconnect_event_in,
    .remote_wake_event_in, .suspend_irq_mode_in, .irq_ack_in, .port_enabled_out, .edp_in, .edp_out, .edp_oe_out,
    .edm_in, .edm_out, .edm_oe_out, .dp_in, .dp_out, .dp_oe_out, .dm_in, .dm_out, .dm_oe_out,
    .interrupt_output_pin_out, .interrupt_output_pin_oe_out);
  rpc_host_model i_host (.ref_clk_in, .sda_in, .scl_out(scl_in), .sda_low_out(sda_low));
  // clock
  initial begin
    forever #10 ref_clk_in = !ref_clk_in;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(6);
  endtask
  task automatic rdchk(input logic [7:0] ofs, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(ofs, d);
    `CHK(d, exp)
  endtask
  // expected pin from output stage: open drain pulls low, push-pull follows level bit
  task automatic irqchk(input logic a);
    `CHK({interrupt_output_pin_oe_out, interrupt_output_pin_out}, pp ? {1'b1, a ^ lo} : {a, 1'b0})
  endtask
  task automatic t_regs();
    rdchk(RPC_OFS_SERIAL, 8'h02);
    rdchk(RPC_OFS_REVISION, RPC_REVISION_CODE);
    rdchk(RPC_OFS_CONTROL, 8'h00);
    rdchk(RPC_OFS_IRQ_EN, 8'h00);
    i_host.wr(8'h60, 8'hFF);
    rdchk(8'h60, 8'h00);
    i_host.wr(RPC_OFS_REVISION, 8'hFF);
    rdchk(RPC_OFS_REVISION, RPC_REVISION_CODE);
    i_host.wr(RPC_OFS_SERIAL, 8'hFF);
    rdchk(RPC_OFS_SERIAL, 8'hDF);
    i_host.wr(RPC_OFS_IRQ_EN, 8'hFF);
    rdchk(RPC_OFS_IRQ_EN, 8'hCC);
    i_host.wr(RPC_OFS_CONTROL, 8'h7F);
    rdchk(RPC_OFS_CONTROL, 8'h58);
    {pp, lo} = 2'b11;
    irqchk(1'b0);
    // soft reset must clear everything the writes above set
    i_host.wr(RPC_OFS_CONTROL, 8'h80);
    {pp, lo} = 2'b00;
    rdchk(RPC_OFS_SERIAL, 8'h02);
    rdchk(RPC_OFS_IRQ_EN, 8'h00);
    rdchk(RPC_OFS_CONTROL, 8'h00);
    irqchk(1'b0);
    $display("registers test done");
  endtask
  // all four swap and direction settings, both data levels
  task automatic t_route();
    logic sw, dr, v;
    for (int m = 0; m < 8; m++) begin
      {sw, dr, v} = m[2:0];
      if (!v) begin
        i_host.wr(RPC_OFS_SERIAL, {3'h0, sw, 1'b1, dr, 2'h3});
      end
      {dp_drv, dm_drv, edp_drv, edm_drv} = {v, v, !v, !v};
      cyc(14);
      `CHK({edm_oe_out, edp_oe_out, dp_oe_out, dm_oe_out}, {sw ^ dr, !(sw ^ dr), dr, !dr})
      `CHK({(sw ^ dr) ? edm_in : edp_in, dr ? dp_in : dm_in}, {v, !v})
    end
    $display("routing test done");
  endtask
  // serial value, pin a level, expected enable
  task automatic t_source();
    logic [9:0] tbl [6] = '{{8'h01, 2'b00}, {8'h01, 2'b11}, {8'h03, 2'b00}, {8'h0A, 2'b10}, {8'h0B, 2'b01},
                            {8'h09, 2'b11}};
    foreach (tbl[i]) begin
      i_host.wr(RPC_OFS_SERIAL, tbl[i][9:2]);
      general_pin_a_in = tbl[i][1];
      cyc(10);
      `CHK(dm_oe_out, tbl[i][0])
    end
    $display("source test done");
  endtask
  task automatic t_irq();
    i_host.wr(RPC_OFS_IRQ_EN, 8'h80);
    general_pin_b_in = 1'b1;
    cyc(10);
    irqchk(1'b1);
    pulse(irq_ack_in);
    irqchk(1'b0);
    i_host.wr(RPC_OFS_IRQ_EN, 8'h40);
    general_pin_b_in = 1'b0;
    cyc(10);
    irqchk(1'b1);
    pulse(irq_ack_in);
    i_host.wr(RPC_OFS_IRQ_EN, 8'h80);
    pin_b_trigger_kind_in = 1'b1;
    cyc(4);
    irqchk(1'b0);
    general_pin_b_in = 1'b1;
    cyc(10);
    irqchk(1'b1);
    general_pin_b_in = 1'b0;
    cyc(10);
    irqchk(1'b0);
    i_host.wr(RPC_OFS_IRQ_EN, 8'h40);
    irqchk(1'b1);
    {pp, lo} = 2'b10;
    i_host.wr(RPC_OFS_CONTROL, 8'h10);
    irqchk(1'b1);
    {pp, lo} = 2'b11;
    i_host.wr(RPC_OFS_CONTROL, 8'h18);
    irqchk(1'b1);
    i_host.wr(RPC_OFS_IRQ_EN, 8'h00);
    irqchk(1'b0);
    {pp, lo} = 2'b00;
    i_host.wr(RPC_OFS_CONTROL, 8'h00);
    pin_b_trigger_kind_in = 1'b0;
    i_host.wr(RPC_OFS_IRQ_EN, 8'h08);
    pulse(remote_wake_event_in);
    irqchk(1'b0);
    suspend_irq_mode_in = 1'b1;
    pulse(remote_wake_event_in);
    irqchk(1'b1);
    pulse(irq_ack_in);
    i_host.wr(RPC_OFS_IRQ_EN, 8'h04);
    pulse(remote_wake_event_in);
    irqchk(1'b0);
    pulse(disconnect_event_in);
    irqchk(1'b1);
    pulse(irq_ack_in);
    i_host.wr(RPC_OFS_IRQ_EN, 8'h00);
    pulse(disconnect_event_in);
    irqchk(1'b0);
    $display("interrupt test done");
  endtask
  task automatic t_shut();
    i_host.wr(RPC_OFS_SERIAL, 8'h0B);
    link_connected_in = 1'b1;
    i_host.wr(RPC_OFS_CONTROL, 8'h40);
    cyc(10);
    `CHK(port_enabled_out, 1'b1)
    // a disconnect means the link is gone as well
    disconnect_event_in = 1'b1;
    link_connected_in = 1'b0;
    cyc(1);
    disconnect_event_in = 1'b0;
    cyc(6);
    `CHK({port_enabled_out, dm_oe_out}, 2'b00)
    i_host.wr(RPC_OFS_CONTROL, 8'h00);
    cyc(2);
    `CHK(port_enabled_out, 1'b1)
    i_host.wr(RPC_OFS_CONTROL, 8'h40);
    cyc(2);
    `CHK(port_enabled_out, 1'b0)
    i_host.wr(RPC_OFS_CONTROL, 8'h00);
    $display("shutdown test done");
  endtask
  task automatic t_pin_reset();
    i_host.wr(RPC_OFS_SERIAL, 8'h00);
    active_low_reset_pin_in = 1'b0;
    cyc(8);
    `CHK(port_enabled_out, 1'b0)
    active_low_reset_pin_in = 1'b1;
    cyc(10);
    rdchk(RPC_OFS_SERIAL, 8'h02);
    $display("reset pin test done");
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    cyc(2);
    srst_in = 1'b0;
    cyc(4);
    t_regs();
    t_route();
    t_source();
    t_irq();
    t_shut();
    t_pin_reset();
    `CHK(i_host.nacks, 0)
    end_sim();
  end
  // cuts a hang short
  initial begin
    repeat (100000) @(posedge ref_clk_in);
    fail_count++;
    end_sim();
  end
endmodule // rpc_port_config_regs_tb_top
`default_nettype wire
